/* hw/pqpw_pkg.sv */
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pqpw_pkg;
	localparam logic [15:0] OFS_POINTER = 16'h0804;
	localparam logic [15:0] OFS_CONTROL = 16'h080c;
	localparam logic [15:0] OFS_RATE    = 16'h0820;
	localparam logic [15:0] OFS_BURST   = 16'h0824;
	localparam logic [15:0] OFS_PM_TH   = 16'h0830;
	localparam logic [15:0] OFS_MONITOR = 16'h0850;

	localparam int BIT_DROPPED_ONLY = 11;
	localparam int BIT_DROP_ALL     = 10;
	localparam int BIT_PORT_BASED   = 7;
	localparam int BIT_MARK_EN      = 4;
	localparam int BIT_REMAP_EN     = 3;
	localparam int BIT_DROP_SRP     = 2;
	localparam int BIT_BLIND        = 1;
	localparam int BIT_ENABLE       = 0;
	localparam int POS_PKT_TYPE     = 8;
	localparam int POS_NONIP_COLOUR = 5;
	localparam int POS_PORT_IDX     = 16;
	localparam int POS_HI           = 16;

	localparam logic [11:0] CONTROL_RST = 12'h020;
	localparam logic [15:0] CIR_RST     = 16'h1000;
	localparam logic [15:0] PIR_RST     = 16'h2000;
	localparam logic [15:0] CBS_RST     = 16'h1000;
	localparam logic [15:0] PBS_RST     = 16'h3000;
	localparam logic [10:0] PM_MAX_RST  = 11'h400;
	localparam logic [10:0] PM_MIN_RST  = 11'h080;
	localparam logic [10:0] LFSR_SEED   = 11'h001;

	localparam int          NUM_PORTS = 5;
	localparam int          NUM_CONN  = 20;
	localparam logic [2:0]  PORT_LAST = 3'h4;

	// Colour codes double as monitor packet-type selectors
	localparam logic [1:0] COL_DROPPED = 2'h0;
	localparam logic [1:0] COL_GREEN   = 2'h1;
	localparam logic [1:0] COL_YELLOW  = 2'h2;
	localparam logic [1:0] COL_RED     = 2'h3;

	typedef struct packed {
		logic        valid;
		logic [2:0]  port;
		logic [1:0]  queue;
		logic [15:0] len;
		logic        is_ip;
		logic        srp;
		logic [1:0]  dscp_colour;
		logic [1:0]  remap_colour;
	} pqpw_pkt_t;

	typedef struct packed {
		logic       valid;
		logic [2:0] port;
		logic [1:0] queue;
		logic [1:0] colour;
		logic       drop;
		logic       mark;
	} pqpw_verdict_t;
endpackage : pqpw_pkg

/* hw/pqpw_top.sv */
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pqpw_top #(
	parameter int CNT_W = 24
) (
	input  wire logic                    clock,
	input  wire logic                    rst_b,
	input  wire logic                    hsel,
	input  wire logic [15:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic [31:0]                  hrdata,
	output logic                         hresp,
	input  wire pqpw_pkg::pqpw_pkt_t     pkt,
	input  wire logic [10:0]             pm_level,
	input  wire logic [10:0]             packet_memory_drop_probability,
	output pqpw_pkg::pqpw_verdict_t      verdict
);
	//--------------------------------------------------------------------------
	// Register state
	//--------------------------------------------------------------------------
	logic [11:0]      ctl;
	logic [2:0]       port_idx;
	logic [1:0]       queue_ptr;
	logic [10:0]      pm_max;
	logic [10:0]      pm_min;
	logic [15:0]      cir [pqpw_pkg::NUM_CONN];
	logic [15:0]      pir [pqpw_pkg::NUM_CONN];
	logic [15:0]      cbs [pqpw_pkg::NUM_CONN];
	logic [15:0]      pbs [pqpw_pkg::NUM_CONN];
	logic [15:0]      ctok [pqpw_pkg::NUM_CONN];
	logic [15:0]      ptok [pqpw_pkg::NUM_CONN];
	logic [CNT_W-1:0] perf_monitor_counter [pqpw_pkg::NUM_CONN][4];
	logic [4:0]       scan;
	logic [10:0]      lfsr;

	//--------------------------------------------------------------------------
	// Bus slave
	//--------------------------------------------------------------------------
	logic        dp_write;
	logic [15:0] dp_addr;
	logic        rd_wait;
	wire         ap_valid = hsel & htrans[1] & hready;
	wire  [4:0]  sel_conn = {port_idx, queue_ptr};
	wire         sel_ok   = port_idx <= pqpw_pkg::PORT_LAST;
	wire         wr_ptr   = dp_write & (dp_addr == pqpw_pkg::OFS_POINTER);
	wire         wr_ctl   = dp_write & (dp_addr == pqpw_pkg::OFS_CONTROL);
	wire         wr_rate  = dp_write & (dp_addr == pqpw_pkg::OFS_RATE) & sel_ok;
	wire         wr_burst = dp_write & (dp_addr == pqpw_pkg::OFS_BURST) & sel_ok;
	wire         wr_pm    = dp_write & (dp_addr == pqpw_pkg::OFS_PM_TH);
	wire  [1:0]  pkt_type = ctl[pqpw_pkg::POS_PKT_TYPE +: 2];
	logic [31:0] rd_mux;

	assign hreadyout = ~rd_wait;
	assign hresp     = 1'b0;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (dp_addr)
			pqpw_pkg::OFS_POINTER: rd_mux = {13'h0000, port_idx, 14'h0000, queue_ptr};
			pqpw_pkg::OFS_CONTROL: rd_mux = {20'h00000, ctl};
			pqpw_pkg::OFS_RATE:    rd_mux = sel_ok ? {cir[sel_conn], pir[sel_conn]} : 32'h0;
			pqpw_pkg::OFS_BURST:   rd_mux = sel_ok ? {cbs[sel_conn], pbs[sel_conn]} : 32'h0;
			pqpw_pkg::OFS_PM_TH:   rd_mux = {5'h00, pm_max, 5'h00, pm_min};
			pqpw_pkg::OFS_MONITOR: begin
				if (sel_ok)
					rd_mux = 32'(perf_monitor_counter[sel_conn][pkt_type]);
			end
			default:               rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			dp_write <= 1'b0;
			dp_addr  <= 16'h0000;
			rd_wait  <= 1'b0;
			hrdata   <= 32'h0000_0000;
		end else begin
			dp_write <= ap_valid & hwrite;
			if (ap_valid)
				dp_addr <= haddr;
			rd_wait  <= ap_valid & ~hwrite;
			if (rd_wait)
				hrdata <= rd_mux;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ctl       <= pqpw_pkg::CONTROL_RST;
			port_idx  <= 3'h0;
			queue_ptr <= 2'h0;
			pm_max    <= pqpw_pkg::PM_MAX_RST;
			pm_min    <= pqpw_pkg::PM_MIN_RST;
		end else begin
			if (wr_ctl)
				ctl <= hwdata[11:0];
			if (wr_ptr) begin
				port_idx  <= hwdata[pqpw_pkg::POS_PORT_IDX +: 3];
				queue_ptr <= hwdata[1:0];
			end
			if (wr_pm) begin
				pm_max <= hwdata[26:16];
				pm_min <= hwdata[10:0];
			end
		end
	end

	//--------------------------------------------------------------------------
	// Metering
	//--------------------------------------------------------------------------
	wire       enable   = ctl[pqpw_pkg::BIT_ENABLE];
	wire [4:0] pol_conn = ctl[pqpw_pkg::BIT_PORT_BASED] ? {pkt.port, pkt.queue}
	                                                    : {3'h0, pkt.queue};
	wire       c_ok     = ctok[pol_conn] >= pkt.len;
	wire       p_ok     = ptok[pol_conn] >= pkt.len;
	wire [1:0] meter    = !p_ok ? pqpw_pkg::COL_RED
	                    : !c_ok ? pqpw_pkg::COL_YELLOW : pqpw_pkg::COL_GREEN;
	wire [1:0] ip_col   = ctl[pqpw_pkg::BIT_REMAP_EN] ? pkt.remap_colour
	                                                  : pkt.dscp_colour;
	wire [1:0] in_col   = pkt.is_ip ? ip_col
	                    : ctl[pqpw_pkg::POS_NONIP_COLOUR +: 2];
	wire       aware    = ~ctl[pqpw_pkg::BIT_BLIND];
	wire [1:0] pol_col  = (aware && in_col > meter) ? in_col : meter;
	wire [1:0] colour   = enable ? pol_col : pqpw_pkg::COL_GREEN;
	wire       cons_p   = pkt.valid & enable & (pol_col != pqpw_pkg::COL_RED);
	wire       cons_c   = pkt.valid & enable & (pol_col == pqpw_pkg::COL_GREEN);

	always_ff @(posedge clock) begin
		if (!rst_b)
			scan <= 5'h00;
		else
			scan <= (scan == 5'(pqpw_pkg::NUM_CONN - 1)) ? 5'h00 : scan + 5'h01;
	end

	// Each connection refills once per scan round and drains on metered packets
	genvar gi;
	generate
		for (gi = 0; gi < pqpw_pkg::NUM_CONN; gi++) begin : g_conn
			wire        refill = scan == 5'(gi);
			wire        hit    = pol_conn == 5'(gi);
			wire [16:0] c_add  = {1'b0, ctok[gi]} + (refill ? {1'b0, cir[gi]} : 17'h0);
			wire [16:0] p_add  = {1'b0, ptok[gi]} + (refill ? {1'b0, pir[gi]} : 17'h0);
			wire [15:0] c_fill = (c_add > {1'b0, cbs[gi]}) ? cbs[gi] : c_add[15:0];
			wire [15:0] p_fill = (p_add > {1'b0, pbs[gi]}) ? pbs[gi] : p_add[15:0];
			// Saturate: a lowered burst size can leave less than the metered length
			wire [15:0] c_use  = (hit & cons_c) ? pkt.len : 16'h0000;
			wire [15:0] p_use  = (hit & cons_p) ? pkt.len : 16'h0000;
			wire [15:0] next_c = (c_fill > c_use) ? c_fill - c_use : 16'h0000;
			wire [15:0] next_p = (p_fill > p_use) ? p_fill - p_use : 16'h0000;
			wire        wsel   = sel_conn == 5'(gi);

			always_ff @(posedge clock) begin
				if (!rst_b) begin
					cir[gi]  <= pqpw_pkg::CIR_RST;
					pir[gi]  <= pqpw_pkg::PIR_RST;
					cbs[gi]  <= pqpw_pkg::CBS_RST;
					pbs[gi]  <= pqpw_pkg::PBS_RST;
					ctok[gi] <= pqpw_pkg::CBS_RST;
					ptok[gi] <= pqpw_pkg::PBS_RST;
				end else begin
					if (wr_rate && wsel) begin
						cir[gi] <= hwdata[pqpw_pkg::POS_HI +: 16];
						pir[gi] <= hwdata[15:0];
					end
					if (wr_burst && wsel) begin
						cbs[gi] <= hwdata[pqpw_pkg::POS_HI +: 16];
						pbs[gi] <= hwdata[15:0];
					end
					ctok[gi] <= next_c;
					ptok[gi] <= next_p;
				end
			end
		end
	endgenerate

	//--------------------------------------------------------------------------
	// Packet memory early drop
	//--------------------------------------------------------------------------
	wire above_min = pm_level > pm_min;
	wire above_max = pm_level > pm_max;
	wire drop_all  = ctl[pqpw_pkg::BIT_DROP_ALL] & above_max;
	wire rand_drop = above_min & (lfsr < packet_memory_drop_probability);
	wire srp_ok    = ~pkt.srp | ctl[pqpw_pkg::BIT_DROP_SRP];
	wire drop      = enable & srp_ok & (drop_all | rand_drop);

	always_ff @(posedge clock) begin
		if (!rst_b)
			lfsr <= pqpw_pkg::LFSR_SEED;
		else
			lfsr <= {lfsr[9:0], lfsr[10] ^ lfsr[8]};
	end

	//--------------------------------------------------------------------------
	// Verdict and monitor counters
	//--------------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			verdict <= '0;
		end else begin
			verdict.valid  <= pkt.valid;
			verdict.port   <= pkt.port;
			verdict.queue  <= pkt.queue;
			verdict.colour <= colour;
			verdict.drop   <= pkt.valid & drop;
			verdict.mark   <= enable & ctl[pqpw_pkg::BIT_MARK_EN];
		end
	end

	wire [4:0] mon_conn = {verdict.port, verdict.queue};
	wire       mon_ok   = verdict.valid & (verdict.port <= pqpw_pkg::PORT_LAST);
	wire       col_inc  = mon_ok & (~ctl[pqpw_pkg::BIT_DROPPED_ONLY] | verdict.drop);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int i = 0; i < pqpw_pkg::NUM_CONN; i++)
				for (int j = 0; j < 4; j++)
					perf_monitor_counter[i][j] <= '0;
		end else begin
			if (mon_ok && verdict.drop)
				perf_monitor_counter[mon_conn][pqpw_pkg::COL_DROPPED] <=
					perf_monitor_counter[mon_conn][pqpw_pkg::COL_DROPPED] + 1'b1;
			if (col_inc)
				perf_monitor_counter[mon_conn][verdict.colour] <=
					perf_monitor_counter[mon_conn][verdict.colour] + 1'b1;
		end
	end

	//--------------------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------------------
	ctl_reset_a: assert property (
		@(posedge clock) !rst_b |=> ctl == pqpw_pkg::CONTROL_RST)
		else $error("control reset value wrong");

	read_wait_a: assert property (
		@(posedge clock) disable iff (!rst_b) ap_valid & ~hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	pm_write_a: assert property (
		@(posedge clock) disable iff (!rst_b) wr_pm |=> pm_max == $past(hwdata[26:16]))
		else $error("threshold write lost");

	disabled_pass_a: assert property (
		@(posedge clock) disable iff (!rst_b) pkt.valid & ~enable
		|=> verdict.valid & !verdict.drop & verdict.colour == pqpw_pkg::COL_GREEN)
		else $error("disabled block acted");

	srp_kept_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		pkt.valid & pkt.srp & ~ctl[pqpw_pkg::BIT_DROP_SRP] |=> !verdict.drop)
		else $error("srp packet dropped");

	drop_all_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		pkt.valid & enable & ctl[pqpw_pkg::BIT_DROP_ALL] & above_max & srp_ok
		|=> verdict.drop)
		else $error("drop all missed");

	nonip_colour_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		pkt.valid & enable & aware & ~pkt.is_ip
		& ctl[pqpw_pkg::POS_NONIP_COLOUR +: 2] == pqpw_pkg::COL_RED
		|=> verdict.colour == pqpw_pkg::COL_RED)
		else $error("non-ip colour ignored");

	mark_follow_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		pkt.valid |=> verdict.mark == $past(enable & ctl[pqpw_pkg::BIT_MARK_EN]))
		else $error("mark flag wrong");

	blind_meter_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		pkt.valid & enable & ~aware |=> verdict.colour == $past(meter))
		else $error("blind colour wrong");

	rate_write_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		wr_rate |=> {cir[sel_conn], pir[sel_conn]} == $past(hwdata))
		else $error("rate write lost");

	burst_write_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		wr_burst |=> {cbs[sel_conn], pbs[sel_conn]} == $past(hwdata))
		else $error("burst write lost");

	ctl_write_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		wr_ctl |=> ctl == $past(hwdata[11:0]))
		else $error("control write lost");

	ptr_write_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		wr_ptr |=> {port_idx, queue_ptr} == $past({hwdata[18:16], hwdata[1:0]}))
		else $error("pointer write lost");

	pm_min_write_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		wr_pm |=> pm_min == $past(hwdata[10:0]))
		else $error("minimum threshold write lost");

	green_tokens_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		pkt.valid & enable & (colour == pqpw_pkg::COL_GREEN) |-> c_ok & p_ok)
		else $error("green without tokens");

	dscp_colour_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		pkt.valid & enable & aware & pkt.is_ip & ~ctl[pqpw_pkg::BIT_REMAP_EN]
		& (pkt.dscp_colour > meter) |=> verdict.colour == $past(pkt.dscp_colour))
		else $error("dscp colour ignored");

	remap_colour_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		pkt.valid & enable & aware & pkt.is_ip & ctl[pqpw_pkg::BIT_REMAP_EN]
		& (pkt.remap_colour > meter) |=> verdict.colour == $past(pkt.remap_colour))
		else $error("remapped colour ignored");

	below_min_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		pkt.valid & ~ctl[pqpw_pkg::BIT_DROP_ALL] & (pm_level <= pm_min) |=> !verdict.drop)
		else $error("drop below minimum threshold");

	bucket_cap_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		!wr_burst |=> (ctok[scan] <= cbs[scan]) & (ptok[scan] <= pbs[scan]))
		else $error("bucket above burst size");

	range_read_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		rd_wait & ~sel_ok & ((dp_addr == pqpw_pkg::OFS_RATE) | (dp_addr == pqpw_pkg::OFS_BURST)
		| (dp_addr == pqpw_pkg::OFS_MONITOR)) |=> hrdata == 32'h0000_0000)
		else $error("out of range read not zero");

	write_ready_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		ap_valid & hwrite |=> hreadyout)
		else $error("write wait state inserted");
endmodule : pqpw_top
`default_nettype wire

/* test/pqpw_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module pqpw_top_test;
	//----------------------------------------------------------------
	// Signals
	//----------------------------------------------------------------
	logic                    clock;
	logic                    rst_b;
	logic                    hsel;
	logic [15:0]             haddr;
	logic [1:0]              htrans;
	logic                    hwrite;
	logic [31:0]             hwdata;
	logic                    hreadyout;
	logic [31:0]             hrdata;
	logic                    hresp;
	pqpw_pkg::pqpw_pkt_t     pkt;
	logic [10:0]             pm_level;
	logic [10:0]             prob;
	pqpw_pkg::pqpw_verdict_t verdict;
	int                      err_count;
	int                      samples_checked;
	logic [31:0]             rd;

	pqpw_top uut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pkt(pkt),
		.pm_level(pm_level), .packet_memory_drop_probability(prob), .verdict(verdict));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	//----------------------------------------------------------------
	// Shared tasks
	//----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		check("hreadyout", {31'h0, hreadyout}, 32'h1);
	endtask : wait_ready

	// Address phase held until accepted, then data phase until ready
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rc(input string name, input logic [15:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask : rc

	task automatic send(input logic [2:0] p, input logic [1:0] q, input logic [15:0] len,
		input logic ip, input logic srp, input logic [1:0] dc, input logic [1:0] rcol,
		input logic [10:0] lvl, input logic [1:0] col, input logic drop, input logic mark);
		pkt <= '{1'b1, p, q, len, ip, srp, dc, rcol};
		pm_level <= lvl;
		@(posedge clock);
		pkt.valid <= 1'b0;
		@(posedge clock);
		check("verdict", {22'h0, verdict.valid, verdict.port, verdict.queue, verdict.colour,
			verdict.drop, verdict.mark}, {22'h0, 1'b1, p, q, col, drop, mark});
		repeat (30) @(posedge clock);
	endtask : send

	//----------------------------------------------------------------
	// Scenarios
	//----------------------------------------------------------------
	task automatic t_regs();
		rc("control", pqpw_pkg::OFS_CONTROL, 32'h00000020);
		rc("rate", pqpw_pkg::OFS_RATE, 32'h10002000);
		rc("burst", pqpw_pkg::OFS_BURST, 32'h10003000);
		rc("thresholds", pqpw_pkg::OFS_PM_TH, 32'h04000080);
		wr(pqpw_pkg::OFS_PM_TH, 32'hffffffff);
		rc("thresholds", pqpw_pkg::OFS_PM_TH, 32'h07ff07ff);
		wr(pqpw_pkg::OFS_CONTROL, 32'hffffffff);
		rc("control", pqpw_pkg::OFS_CONTROL, 32'h00000fff);
		wr(16'h0900, 32'hffffffff);
		rc("unmapped", 16'h0900, 32'h0);
		wr(pqpw_pkg::OFS_PM_TH, 32'h04000080);
	endtask : t_regs

	task automatic t_pointer();
		wr(pqpw_pkg::OFS_POINTER, 32'h00020003);
		wr(pqpw_pkg::OFS_RATE, 32'h11112222);
		rc("rate", pqpw_pkg::OFS_RATE, 32'h11112222);
		wr(pqpw_pkg::OFS_POINTER, 32'h0);
		rc("rate", pqpw_pkg::OFS_RATE, 32'h10002000);
		wr(pqpw_pkg::OFS_POINTER, 32'hffffffff);
		rc("pointer", pqpw_pkg::OFS_POINTER, 32'h00070003);
		wr(pqpw_pkg::OFS_RATE, 32'h12345678);
		rc("rate", pqpw_pkg::OFS_RATE, 32'h0);
	endtask : t_pointer

	task automatic t_meter();
		wr(pqpw_pkg::OFS_CONTROL, 32'h10);
		send(3'h1, 2'h0, 16'hffff, 1'b0, 1'b0, 2'h0, 2'h0, 11'h7ff, 2'h1, 1'b0, 1'b0);
		wr(pqpw_pkg::OFS_CONTROL, 32'h13);
		send(3'h1, 2'h1, 16'h0100, 1'b0, 1'b0, 2'h0, 2'h0, 11'h0, 2'h1, 1'b0, 1'b1);
		send(3'h1, 2'h1, 16'h2000, 1'b0, 1'b0, 2'h0, 2'h0, 11'h0, 2'h2, 1'b0, 1'b1);
		send(3'h1, 2'h1, 16'h4000, 1'b0, 1'b0, 2'h0, 2'h0, 11'h0, 2'h3, 1'b0, 1'b1);
		wr(pqpw_pkg::OFS_CONTROL, 32'h61);
		send(3'h1, 2'h1, 16'h0010, 1'b0, 1'b0, 2'h1, 2'h1, 11'h0, 2'h3, 1'b0, 1'b0);
		wr(pqpw_pkg::OFS_CONTROL, 32'h41);
		send(3'h1, 2'h1, 16'h0010, 1'b0, 1'b0, 2'h1, 2'h1, 11'h0, 2'h2, 1'b0, 1'b0);
		send(3'h1, 2'h1, 16'h0010, 1'b1, 1'b0, 2'h2, 2'h3, 11'h0, 2'h2, 1'b0, 1'b0);
		wr(pqpw_pkg::OFS_CONTROL, 32'h49);
		send(3'h1, 2'h1, 16'h0010, 1'b1, 1'b0, 2'h2, 2'h3, 11'h0, 2'h3, 1'b0, 1'b0);
	endtask : t_meter

	task automatic t_scope();
		wr(pqpw_pkg::OFS_POINTER, 32'h00000002);
		wr(pqpw_pkg::OFS_BURST, 32'h00100020);
		wr(pqpw_pkg::OFS_CONTROL, 32'h03);
		repeat (30) @(posedge clock);
		send(3'h3, 2'h2, 16'h0018, 1'b0, 1'b0, 2'h0, 2'h0, 11'h0, 2'h2, 1'b0, 1'b0);
		wr(pqpw_pkg::OFS_CONTROL, 32'h83);
		send(3'h3, 2'h2, 16'h0018, 1'b0, 1'b0, 2'h0, 2'h0, 11'h0, 2'h1, 1'b0, 1'b0);
	endtask : t_scope

	task automatic t_drop();
		wr(pqpw_pkg::OFS_CONTROL, 32'h403);
		send(3'h4, 2'h3, 16'h0010, 1'b0, 1'b0, 2'h0, 2'h0, 11'h401, 2'h1, 1'b1, 1'b0);
		send(3'h4, 2'h3, 16'h0010, 1'b0, 1'b0, 2'h0, 2'h0, 11'h400, 2'h1, 1'b0, 1'b0);
		send(3'h4, 2'h3, 16'h0010, 1'b0, 1'b1, 2'h0, 2'h0, 11'h7ff, 2'h1, 1'b0, 1'b0);
		wr(pqpw_pkg::OFS_CONTROL, 32'h407);
		send(3'h4, 2'h3, 16'h0010, 1'b0, 1'b1, 2'h0, 2'h0, 11'h7ff, 2'h1, 1'b1, 1'b0);
		wr(pqpw_pkg::OFS_CONTROL, 32'h003);
		prob <= 11'h7ff;
		send(3'h4, 2'h3, 16'h0010, 1'b0, 1'b0, 2'h0, 2'h0, 11'h080, 2'h1, 1'b0, 1'b0);
		prob <= 11'h000;
		send(3'h4, 2'h3, 16'h0010, 1'b0, 1'b0, 2'h0, 2'h0, 11'h7ff, 2'h1, 1'b0, 1'b0);
		wr(pqpw_pkg::OFS_CONTROL, 32'h406);
		send(3'h4, 2'h3, 16'h0010, 1'b0, 1'b1, 2'h0, 2'h0, 11'h7ff, 2'h1, 1'b0, 1'b0);
	endtask : t_drop

	task automatic t_monitor();
		logic [31:0] exp_cnt [4];
		exp_cnt = '{32'h1, 32'h2, 32'h0, 32'h1};
		wr(pqpw_pkg::OFS_CONTROL, 32'h403);
		send(3'h2, 2'h1, 16'h0010, 1'b0, 1'b0, 2'h0, 2'h0, 11'h500, 2'h1, 1'b1, 1'b0);
		send(3'h2, 2'h1, 16'h0010, 1'b0, 1'b0, 2'h0, 2'h0, 11'h0, 2'h1, 1'b0, 1'b0);
		send(3'h2, 2'h1, 16'h4000, 1'b0, 1'b0, 2'h0, 2'h0, 11'h0, 2'h3, 1'b0, 1'b0);
		wr(pqpw_pkg::OFS_POINTER, 32'h00020001);
		for (int t = 0; t < 4; t++) begin
			wr(pqpw_pkg::OFS_CONTROL, 32'h403 | (t << 8));
			rc("monitor", pqpw_pkg::OFS_MONITOR, exp_cnt[t]);
		end
		wr(pqpw_pkg::OFS_CONTROL, 32'hc03);
		send(3'h2, 2'h1, 16'h0010, 1'b0, 1'b0, 2'h0, 2'h0, 11'h500, 2'h1, 1'b1, 1'b0);
		send(3'h2, 2'h1, 16'h0010, 1'b0, 1'b0, 2'h0, 2'h0, 11'h0, 2'h1, 1'b0, 1'b0);
		wr(pqpw_pkg::OFS_CONTROL, 32'hd03);
		rc("monitor", pqpw_pkg::OFS_MONITOR, 32'h3);
		wr(pqpw_pkg::OFS_CONTROL, 32'hc03);
		rc("monitor", pqpw_pkg::OFS_MONITOR, 32'h2);
	endtask : t_monitor

	//----------------------------------------------------------------
	// Run control
	//----------------------------------------------------------------
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		$display("watchdog expired");
		wrap_up();
	end

	initial begin
		err_count = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = 16'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		pkt = '0;
		pm_level = 11'h0;
		prob = 11'h0;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		check("verdict reset", 32'(verdict), 32'h0);
		check("hrdata reset", hrdata, 32'h0);
		t_regs();
		t_pointer();
		t_meter();
		t_scope();
		t_drop();
		t_monitor();
		wrap_up();
	end
endmodule : pqpw_top_test
`default_nettype wire
